// >>> verilog/pid_defs.svh
// Purpose: Offsets, field limits and rate counts of the PID regulator.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef PID_DEFS_SVH
`define PID_DEFS_SVH

// ==========================================================================
// Register offsets (word addresses on the register port)
`define OFS_PROP_GAIN     8'h20
`define OFS_INTEG_GAIN    8'h21
`define OFS_DIFF_GAIN     8'h22
`define OFS_INTEG_LIMIT   8'h23
`define OFS_INTEG_ACCUM   8'h24
`define OFS_DIFF_DIVIDER  8'h25
`define OFS_VEL_LIMIT     8'h27
`define OFS_DEVIATION     8'h28
`define OFS_CORR_VELOCITY 8'h29
`define OFS_DEADBAND      8'h2a

// ==========================================================================
// Rates and scaling
`define UPD_DIV          128
`define UPD_DIV_CODE     7'h00
`define TERM_SHIFT       8
`define DIFF_DIV_ZERO    256
`define DELTA_LIM        32'h0000_007f
`define VEL_LIMIT_ZEROS  8'h00
`define ILIMIT_ZEROS     16'h0000
`define DEV_POS_LIM      33'sh0_007f_ffff
`define DEV_NEG_LIM      (-33'sh0_0080_0000)
`define DEV_MAX          24'h7f_ffff
`define DEV_MIN          24'h80_0000
`define SAT32_MAX        32'h7fff_ffff
`define SAT32_MIN        32'h8000_0000

`endif

// >>> verilog/pid_pkg.sv
// Purpose: Types shared by the PID regulator files.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes:   Numeric constants live in pid_defs.svh.
`default_nettype none
package pid_pkg;

    // ======================================================================
    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_s;

    // ======================================================================
    // Motion inputs from ramp generator and encoder counter
    typedef struct packed {
        logic [31:0] enc_x;
        logic [31:0] x_actual;
        logic [31:0] v_actual;
        logic        target_hit;
        logic        base_sel;
    } axis_in_s;

    // ======================================================================
    // State of the regulator apart from the rate divider counters
    typedef struct packed {
        logic [23:0] p_gain;
        logic [23:0] i_gain;
        logic [23:0] d_gain;
        logic [14:0] i_limit;
        logic [7:0]  d_div;
        logic [30:0] vel_limit;
        logic [19:0] deadband;
        logic [23:0] dev;
        logic [31:0] isum;
        logic [23:0] d_last;
        logic [7:0]  d_delta;
        logic [31:0] result;
        logic [31:0] vel_out;
        logic [31:0] vel_rb;
        logic [31:0] rdata;
    } pid_state_s;

endpackage
`default_nettype wire

// >>> verilog/pulse_divider.sv
// Purpose: Counts input ticks and emits one pulse every divisor ticks.
// Assumes: Divisor value zero stands for 2^W.
// Notes:   Output pulse is registered, one cycle after the last tick.
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] divisor,
    output logic              tick_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         pulse;
    } div_state_s;

    div_state_s st;
    div_state_s next_st;
    logic [W-1:0] last_cnt;

    // ======================================================================
    // Wrap point; zero minus one wraps to all ones, giving 2^W
    always_comb begin
        last_cnt = divisor - {{(W-1){1'b0}}, 1'b1};
        next_st = st;
        next_st.pulse = 1'b0;
        if (tick_in) begin
            // A count left past a lowered divisor wraps now, not after 2^W
            if (st.cnt >= last_cnt) begin
                next_st.cnt = '0;
                next_st.pulse = 1'b1;
            end else begin
                next_st.cnt = st.cnt + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_out = st.pulse;
endmodule
`default_nettype wire

// >>> verilog/gain_term.sv
// Purpose: Signed operand times unsigned gain, shifted, clipped to 32 bits.
// Assumes: Gain is unsigned 24 bits; operand is signed.
// Notes:   Purely combinational; the caller registers the sum.
`include "pid_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module gain_term #(
    parameter int OW    = 24,
    parameter int SHIFT = 8
) (
    input  wire logic [OW-1:0] operand,
    input  wire logic [23:0]   gain,
    output logic [31:0]        term
);
    localparam int PW = OW + 25;

    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] scaled;

    // ======================================================================
    // Product is exact; only the final clip loses range
    always_comb begin
        prod = $signed(operand) * $signed({1'b0, gain});
        scaled = prod >>> SHIFT;
        if (gain == 24'h00_0000) begin
            term = 32'h0000_0000; // Zero gain removes the term
        end else if (scaled > $signed({{(PW-32){1'b0}}, `SAT32_MAX})) begin
            term = `SAT32_MAX;
        end else if (scaled < $signed({{(PW-32){1'b1}}, `SAT32_MIN})) begin
            term = `SAT32_MIN;
        end else begin
            term = scaled[31:0];
        end
    end
endmodule
`default_nettype wire

// >>> verilog/pid_position_regulator.sv
// Purpose: PID position regulator for one axis with register access.
// Assumes: Axis inputs come from logic on core_clk; no synchronising.
// Notes:   Rate dividers and term multipliers are instantiated below.
`include "pid_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pid_position_regulator (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire pid_pkg::reg_req_s reg_req,
    input  wire pid_pkg::axis_in_s axis_in,
    output logic [31:0]            reg_rdata,
    output logic [31:0]            corrected_velocity
);
    import pid_pkg::*;

    pid_state_s  st;
    pid_state_s  next_st;
    logic        upd;
    logic        d_tick;
    logic [32:0] diff;
    logic [24:0] abs_dev;
    logic        in_deadband;
    logic [23:0] err_in;
    logic [31:0] p_term;
    logic [31:0] i_term;
    logic [31:0] d_term;
    logic signed [40:0] term_sum;
    logic signed [40:0] limited;
    logic signed [40:0] isum_next;
    logic signed [40:0] delta;
    logic        wr_isum;

    // ======================================================================
    // Helpers
    function automatic logic signed [40:0] ext32(input logic [31:0] v);
        ext32 = $signed({{9{v[31]}}, v});
    endfunction

    // Symmetric clip to +/- lim
    function automatic logic signed [40:0] clip_lim(
        input logic signed [40:0] v,
        input logic [31:0]        lim
    );
        logic signed [40:0] l;
        l = $signed({9'h000, lim});
        if (v > l) begin
            clip_lim = l;
        end else if (v < -l) begin
            clip_lim = -l;
        end else begin
            clip_lim = v;
        end
    endfunction

    // Two's complement 32 bit saturation
    function automatic logic [31:0] sat32(input logic signed [40:0] v);
        if (v > ext32(`SAT32_MAX)) begin
            sat32 = `SAT32_MAX;
        end else if (v < ext32(`SAT32_MIN)) begin
            sat32 = `SAT32_MIN;
        end else begin
            sat32 = v[31:0];
        end
    endfunction

    // ======================================================================
    // Update rate and differential sampling rate
    pulse_divider #(
        .W (7)
    ) u_upd_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick_in  (1'b1),
        .divisor  (`UPD_DIV_CODE),
        .tick_out (upd)
    );

    pulse_divider #(
        .W (8)
    ) u_d_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick_in  (upd),
        .divisor  (st.d_div),
        .tick_out (d_tick)
    );

    // ======================================================================
    // Term multipliers
    gain_term #(
        .OW    (24),
        .SHIFT (`TERM_SHIFT)
    ) u_p (
        .operand (err_in),
        .gain    (st.p_gain),
        .term    (p_term)
    );

    // Integrator divided by 256 before the gain keeps the product narrow
    gain_term #(
        .OW    (24),
        .SHIFT (`TERM_SHIFT)
    ) u_i (
        .operand (st.isum[31:8]),
        .gain    (st.i_gain),
        .term    (i_term)
    );

    gain_term #(
        .OW    (8),
        .SHIFT (0)
    ) u_d (
        .operand (st.d_delta),
        .gain    (st.d_gain),
        .term    (d_term)
    );

    // ======================================================================
    // Next state: deviation, integrator, terms, registers
    always_comb begin
        next_st = st;
        wr_isum = reg_req.wr && (reg_req.addr == `OFS_INTEG_ACCUM);

        // Deviation saturates rather than wraps on large following errors
        diff = $signed({axis_in.enc_x[31], axis_in.enc_x})
             - $signed({axis_in.x_actual[31], axis_in.x_actual});
        if ($signed(diff) > `DEV_POS_LIM) begin
            next_st.dev = `DEV_MAX;
        end else if ($signed(diff) < `DEV_NEG_LIM) begin
            next_st.dev = `DEV_MIN;
        end else begin
            next_st.dev = diff[23:0];
        end

        // Deadband applies only once the ramp reports an exact hit
        abs_dev = st.dev[23] ? (25'h000_0000 - {1'b1, st.dev})
                             : {1'b0, st.dev};
        in_deadband = axis_in.target_hit
                   && (abs_dev < {5'h00, st.deadband});
        err_in = in_deadband ? 24'h00_0000 : st.dev;

        // Sum of terms, then velocity correction clip
        term_sum = ext32(p_term) + ext32(i_term) + ext32(d_term);
        if (st.vel_limit == 31'h0000_0000) begin
            limited = '0;
        end else begin
            limited = clip_lim(term_sum, {1'b0, st.vel_limit});
        end

        // Integrator step
        isum_next = clip_lim(ext32(st.isum)
                             + $signed({{17{err_in[23]}}, err_in}),
                             {1'b0, st.i_limit, `ILIMIT_ZEROS});
        if (upd) begin
            next_st.isum = isum_next[31:0];
            next_st.result = limited[31:0];
        end
        if (in_deadband) begin
            next_st.isum = 32'h0000_0000;
        end

        // Differential sample: previous minus current
        delta = clip_lim($signed({{17{st.d_last[23]}}, st.d_last})
                         - $signed({{17{err_in[23]}}, err_in}),
                         `DELTA_LIM);
        if (d_tick) begin
            next_st.d_delta = delta[7:0];
            next_st.d_last = err_in;
        end

        // Outputs derived from the registered result
        next_st.vel_out = sat32(ext32(axis_in.v_actual)
                                + ext32(st.result));
        next_st.vel_rb = axis_in.base_sel ? st.vel_out : st.result;

        // Register writes; the integrator ignores write data
        if (reg_req.wr) begin
            case (reg_req.addr)
                `OFS_PROP_GAIN:    next_st.p_gain = reg_req.wdata[23:0];
                `OFS_INTEG_GAIN:   next_st.i_gain = reg_req.wdata[23:0];
                `OFS_DIFF_GAIN:    next_st.d_gain = reg_req.wdata[23:0];
                `OFS_INTEG_LIMIT:  next_st.i_limit = reg_req.wdata[14:0];
                `OFS_INTEG_ACCUM:  next_st.isum = 32'h0000_0000;
                `OFS_DIFF_DIVIDER: next_st.d_div = reg_req.wdata[7:0];
                `OFS_VEL_LIMIT: begin
                    next_st.vel_limit = {reg_req.wdata[30:8],
                                         `VEL_LIMIT_ZEROS};
                end
                `OFS_DEADBAND:     next_st.deadband = reg_req.wdata[19:0];
                default: begin
                end
            endcase
        end

        // Reads; write-only and unmapped words return zero
        if (reg_req.rd) begin
            case (reg_req.addr)
                `OFS_INTEG_ACCUM:   next_st.rdata = st.isum;
                `OFS_DEVIATION: begin
                    next_st.rdata = {{8{st.dev[23]}}, st.dev};
                end
                `OFS_CORR_VELOCITY: next_st.rdata = st.vel_rb;
                default:            next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign corrected_velocity = st.vel_out;

    // ======================================================================
    // Checks and helper counters
    logic [8:0] upd_since_d;
    logic       div_dirty;

    // Counts updates between differential samples
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            upd_since_d <= 9'h000;
            div_dirty <= 1'b0;
        end else begin
            if (d_tick) begin
                upd_since_d <= {8'h00, upd};
            end else if (upd) begin
                upd_since_d <= upd_since_d + 9'h001;
            end
            if (reg_req.wr && reg_req.addr == `OFS_DIFF_DIVIDER) begin
                div_dirty <= 1'b1;
            end else if (d_tick) begin
                div_dirty <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_upd_period: assert property (upd |-> ##128 upd)
        else $error("update pulse spacing not 128");
    a_upd_single: assert property (upd |=> !upd[*8])
        else $error("update pulse repeated");
    a_p_zero_gain: assert property ((st.p_gain == 24'h00_0000)
                                    |-> p_term == 32'h0000_0000)
        else $error("P term present with zero gain");
    a_i_zero_gain: assert property ((st.i_gain == 24'h00_0000)
                                    |-> i_term == 32'h0000_0000)
        else $error("I term present with zero gain");
    a_d_delta_range: assert property ($signed(st.d_delta)
                                      >= -8'sd127)
        else $error("differential delta outside 127");
    a_d_rate: assert property ((d_tick && !div_dirty) |->
        upd_since_d == ((st.d_div == 8'h00) ? 9'd256
                                             : {1'b0, st.d_div}))
        else $error("differential sample rate wrong");
    a_isum_clip: assert property ((upd && !reg_req.wr) |=>
        ($signed(st.isum) <= $signed({1'b0, st.i_limit, 16'h0000}))
        && ($signed(st.isum) >= -$signed({1'b0, st.i_limit, 16'h0000})))
        else $error("integrator beyond its limit");
    a_isum_clear: assert property ((wr_isum && !upd) |=>
        st.isum == 32'h0000_0000)
        else $error("integrator not cleared by write");
    a_vel_disable: assert property ((upd && st.vel_limit == 31'h0)
        |=> st.result == 32'h0000_0000 ##2
        corrected_velocity == $past(axis_in.v_actual))
        else $error("regulation active with zero limit");
    a_dev_sat: assert property ($signed(diff) > `DEV_POS_LIM
        |=> st.dev == `DEV_MAX)
        else $error("deviation not saturated");
    a_rb_base: assert property (!axis_in.base_sel
        |=> st.vel_rb == $past(st.result))
        else $error("readback not bare result");
    a_deadband_hold: assert property (in_deadband
        |=> st.isum == 32'h0000_0000)
        else $error("integrator not held in deadband");

    c_regulating: cover property (upd && st.vel_limit != 31'h0
                                  && term_sum != 41'sh0);
    c_deadband: cover property (in_deadband && st.deadband != 20'h0);
    c_isum_write: cover property (wr_isum ##1 upd);
    c_d_div256: cover property (d_tick && st.d_div == 8'h00);
endmodule
`default_nettype wire

// >>> tb/pid_position_regulator_test.sv
// Purpose: Self-checking bench for the PID position regulator.
// Assumes: Update pulses fall every 128 cycles counted from reset release.
// Notes:   Samples are taken mid-period, far from any update pulse.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Comparison helper
`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) begin \
            failures++; \
            $display("BAD %s exp %h got %h", nm, ex, got); \
        end \
    end

module pid_position_regulator_test;
    import pid_pkg::*;

    localparam int TMO = 20000;  // Tests need about 8000 cycles

    logic               core_clk;
    logic               rst_n;
    reg_req_s           req;
    axis_in_s           ax;
    logic [31:0]        rdata;
    logic [31:0]        cvel;
    logic [31:0]        q;
    int                 failures;
    int                 n_checks;
    int                 cyc;
    int                 ticks;

    pid_position_regulator uut (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .reg_req            (req),
        .axis_in            (ax),
        .reg_rdata          (rdata),
        .corrected_velocity (cvel)
    );

    // ======================================================================
    // Clock, phase counter and hang guard
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Phase tracks the update pulse so checks avoid its edge
    always @(posedge core_clk) begin
        ticks <= ticks + 1;
        cyc   <= rst_n ? cyc + 1 : 0;
    end

    // ======================================================================
    // Bus and timing tasks
    task automatic finish_test();
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One-cycle write strobe, released the cycle after it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        #1;
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = d;
        @(posedge core_clk);
        #1;
        req.wr    = 1'b0;
    endtask

    // Read data is registered at the strobe edge, so take it just after
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        #1;
        req.rd   = 1'b1;
        req.addr = a;
        @(posedge core_clk);
        #1;
        req.rd   = 1'b0;
        v        = rdata;
    endtask

    // Go to the middle of the n-th following update period
    task automatic mid(input int n);
        repeat (n) begin
            @(posedge core_clk);
            while ((cyc % 128) != 64) begin
                @(posedge core_clk);
            end
        end
        #1;
    endtask

    // ======================================================================
    // Scenarios
    task automatic check_reset();
        `CHK("cvel reset", 32'h0000_0000, cvel)
        ax.enc_x    = 32'd10;
        ax.x_actual = 32'd3;
        wr(8'h28, 32'h0000_5555);
        rd(8'h28, q);
        `CHK("dev order", 32'h0000_0007, q)
        ax.enc_x = 32'h0100_0000;
        rd(8'h28, q);
        `CHK("dev sat hi", 32'h007f_ffff, q)
        ax.enc_x    = 32'h0000_0000;
        ax.x_actual = 32'h0100_0000;
        rd(8'h28, q);
        `CHK("dev sat lo", 32'hff80_0000, q)
        rd(8'h26, q);
        `CHK("unmapped", 32'h0000_0000, q)
    endtask

    task automatic check_prop();
        ax.x_actual = 32'h0000_0000;
        ax.enc_x    = 32'd1000;
        ax.v_actual = 32'd100;
        wr(8'h20, 32'h0000_0200);
        mid(2);
        `CHK("cvel off", 32'd100, cvel)
        wr(8'h27, 32'h7fff_ffff);
        mid(2);
        `CHK("cvel p", 32'd2100, cvel)
        ax.base_sel = 1'b1;
        mid(1);
        rd(8'h29, q);
        `CHK("rb base1", 32'd2100, q)
        ax.base_sel = 1'b0;
        mid(1);
        rd(8'h29, q);
        `CHK("rb base0", 32'd2000, q)
        // Low byte of the limit is dropped, leaving 256
        wr(8'h27, 32'h0000_01ff);
        mid(2);
        `CHK("clip pos", 32'd356, cvel)
        ax.enc_x = 32'hffff_fc18;
        mid(2);
        `CHK("clip neg", 32'hffff_ff64, cvel)
        wr(8'h27, 32'h7fff_ffff);
        wr(8'h20, 32'h00ff_ffff);
        ax.enc_x    = 32'h0100_0000;
        ax.v_actual = 32'h0000_1000;
        mid(2);
        `CHK("cvel sat", 32'h7fff_ffff, cvel)
        ax.base_sel = 1'b1;
        mid(1);
        rd(8'h29, q);
        `CHK("rb sat", 32'h7fff_ffff, q)
        ax.base_sel = 1'b0;
        mid(1);
        rd(8'h29, q);
        `CHK("rb bare", 32'h7fff_ff00, q)
        wr(8'h20, 32'h0000_0000);
        mid(2);
        `CHK("p gain 0", 32'h0000_1000, cvel)
    endtask

    task automatic check_integ();
        ax.v_actual = 32'h0000_0000;
        ax.x_actual = 32'h0000_0000;
        ax.enc_x    = 32'h0100_0000;
        wr(8'h23, 32'h0000_0001);
        mid(1);
        wr(8'h24, 32'h1234_5678);
        rd(8'h24, q);
        `CHK("isum clear", 32'h0000_0000, q)
        mid(2);
        rd(8'h24, q);
        `CHK("isum hi", 32'h0001_0000, q)
        ax.enc_x = 32'hff00_0000;
        mid(2);
        rd(8'h24, q);
        `CHK("isum lo", 32'hffff_0000, q)
        wr(8'h21, 32'h0000_0200);
        mid(2);
        `CHK("i term", 32'hffff_fe00, cvel)
        wr(8'h20, 32'h0000_0100);
        mid(2);
        `CHK("p plus i", 32'hff7f_fe00, cvel)
    endtask

    // A deviation step yields one clipped delta held for div updates
    task automatic check_deriv(input int div, input logic [31:0] d0,
                               input logic [31:0] d1, input logic [31:0] ex);
        int hits;
        hits = 0;
        wr(8'h20, 32'h0000_0000);
        wr(8'h21, 32'h0000_0000);
        wr(8'h22, 32'h0000_0002);
        wr(8'h25, 32'(div));
        ax.enc_x = d0;
        mid(8);
        ax.enc_x = d1;
        repeat (8) begin
            mid(1);
            if (cvel === ex) begin
                hits++;
            end
        end
        `CHK("d hits", div, hits)
    endtask

    task automatic check_dead();
        wr(8'h22, 32'h0000_0000);
        wr(8'h20, 32'h0000_0100);
        wr(8'h23, 32'h0000_7f80);
        wr(8'h2a, 32'd100);
        ax.target_hit = 1'b1;
        ax.enc_x      = 32'd50;
        wr(8'h24, 32'h0000_0000);
        mid(2);
        `CHK("dead cvel", 32'h0000_0000, cvel)
        rd(8'h24, q);
        `CHK("dead isum", 32'h0000_0000, q)
        ax.enc_x = 32'd200;
        mid(2);
        `CHK("dead leave", 32'd200, cvel)
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        req      = '0;
        ax       = '0;
        rst_n    = 1'b0;
        failures = 0;
        n_checks = 0;
        repeat (3) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        // Scenarios race the hang guard; whichever ends first closes the run
        fork
            begin
                check_reset();
                check_prop();
                check_integ();
                check_deriv(1, 32'd0, 32'd1000, 32'hffff_ff02);
                check_deriv(3, 32'd1000, 32'd0, 32'h0000_00fe);
                check_dead();
            end
            begin
                wait (ticks >= TMO);
                failures++;
            end
        join_any
        finish_test();
    end
endmodule
`default_nettype wire
